// [pkg/ubpp_pkg.sv]
/*
  Shared constants and types for the byte-wide bit-bang parallel port.
  Assumes one 100 MHz channel clock and byte-wide FIFOs on the host side.
*/
`default_nettype none

package ubpp_pkg;

  // ----------------------------------------------------------------
  // Widths, codes and reset values
  // ----------------------------------------------------------------
  localparam int          PIN_W           = 8;
  localparam logic [7:0]  MODE_ASYNC_CODE = 8'h01;
  localparam logic [7:0]  MODE_SYNC_CODE  = 8'h04;
  localparam logic [7:0]  OUT_RST         = 8'h00;
  localparam logic [7:0]  DIR_RST         = 8'h00;
  localparam logic [7:0]  DIR_ALL_IN      = 8'h00;
  localparam logic        STROBE_IDLE     = 1'b1;
  localparam logic        STROBE_ACTIVE   = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_NS      = 10;
  localparam int STROBE_NS     = 10;
  localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UBPP_MODE_OFF   = 3'b001,
    UBPP_MODE_ASYNC = 3'b010,
    UBPP_MODE_SYNC  = 3'b100
  } ubpp_mode_t;

  typedef enum logic [3:0] {
    UBPP_S_IDLE  = 4'b0001,
    UBPP_S_FWD   = 4'b0010,
    UBPP_S_SETUP = 4'b0100,
    UBPP_S_WSTB  = 4'b1000
  } ubpp_state_t;

  localparam ubpp_mode_t MODE_RST = UBPP_MODE_OFF;

endpackage : ubpp_pkg

`default_nettype wire

// [pkg/ubpp_pin_if.sv]
/*
  Carrier between the port sequencer and the pin bank.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface ubpp_pin_if;
  // Output data and direction loads, each a one-cycle request.
  logic                       load_data;
  logic [ubpp_pkg::PIN_W-1:0] data;
  logic                       load_dir;
  logic [ubpp_pkg::PIN_W-1:0] dir;

  modport ctrl (output load_data, data, load_dir, dir);
  modport bank (input  load_data, data, load_dir, dir);
endinterface : ubpp_pin_if

`default_nettype wire

// [design/ubpp_pin_bank.sv]
/*
  Eight parallel pins, each with its own direction bit and output latch.
  Assumes the load requests come from the sequencer on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ubpp_pin_bank (
  input  wire logic                       ref_clk_i,   // Channel clock.
  input  wire logic                       rst_b_i,     // Async reset, active low.
  ubpp_pin_if.bank                        ctl,         // Load requests.
  output logic [ubpp_pkg::PIN_W-1:0]      pin_o,       // Pin output levels.
  output logic [ubpp_pkg::PIN_W-1:0]      pin_oe_n_o   // Low while the pin drives.
);
  import ubpp_pkg::*;

  logic [PIN_W-1:0] data_r;
  logic [PIN_W-1:0] data_nxt;
  logic [PIN_W-1:0] dir_r;
  logic [PIN_W-1:0] dir_nxt;
  logic [PIN_W-1:0] pin_r;
  logic [PIN_W-1:0] pin_nxt;
  logic [PIN_W-1:0] oe_n_r;
  logic [PIN_W-1:0] oe_n_nxt;

  // ----------------------------------------------------------------
  // Per-pin next values
  // ----------------------------------------------------------------
  // Each pin keeps its own direction; an input pin never shows latch data.
  // per-pin direction
  for (genvar i = 0; i < PIN_W; i++) begin : g_pin
    always_comb begin
      data_nxt[i] = ctl.load_data ? ctl.data[i] : data_r[i];
      dir_nxt[i]  = ctl.load_dir ? ctl.dir[i] : dir_r[i];
      pin_nxt[i]  = data_nxt[i] & dir_nxt[i];
      oe_n_nxt[i] = ~dir_nxt[i];
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_r <= OUT_RST;
      dir_r  <= DIR_RST;
      pin_r  <= OUT_RST & DIR_RST;
      oe_n_r <= ~DIR_RST;
    end else begin
      data_r <= data_nxt;
      dir_r  <= dir_nxt;
      pin_r  <= pin_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign pin_o      = pin_r;
  assign pin_oe_n_o = oe_n_r;

endmodule : ubpp_pin_bank

`default_nettype wire

// [design/ubpp_port.sv]
/*
  Byte-wide bit-bang parallel port of one bridge channel: sequencer,
  mode register, sample path and strobes, with the pin bank below it.
  Assumes byte FIFOs on the host side with valid/ready, a one-cycle
  baud tick, and pin inputs already synchronous to the channel clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ubpp_port (
  input  wire logic                       ref_clk_i,               // Channel clock.
  input  wire logic                       rst_b_i,                 // Async reset, low.
  input  wire logic                       setup_valid_i,           // Setup command.
  input  wire logic [7:0]                 setup_mode_i,            // Mode code.
  input  wire logic [ubpp_pkg::PIN_W-1:0] setup_mask_i,            // 1 = output.
  output logic                            setup_ready_o,           // Setup taken.
  input  wire logic                       baud_tick_i,             // Baud tick.
  input  wire logic                       fh_valid_i,              // Host byte ready.
  input  wire logic [7:0]                 fh_data_i,               // Host byte.
  output logic                            fh_ready_o,              // Pop host byte.
  output logic                            th_valid_o,              // Push sample.
  output logic [7:0]                      th_data_o,               // Sampled pins.
  input  wire logic                       th_ready_i,              // Room to host.
  input  wire logic [ubpp_pkg::PIN_W-1:0] pin_i,                   // Pin levels.
  output logic [ubpp_pkg::PIN_W-1:0]      pin_o,                   // Pin drive.
  output logic [ubpp_pkg::PIN_W-1:0]      pin_oe_n_o,              // Low = driving.
  output logic                            pin_sample_strobe_n_o,   // Read strobe.
  output logic                            pin_update_strobe_n_o,   // Write strobe.
  output ubpp_pkg::ubpp_mode_t            mode_o                   // Current mode.
);
  import ubpp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ubpp_pin_if pif ();

  ubpp_state_t      state_r;
  ubpp_state_t      state_nxt;
  ubpp_mode_t       mode_r;
  ubpp_mode_t       mode_nxt;
  logic [7:0]       hold_r;
  logic [7:0]       hold_nxt;
  logic [7:0]       th_data_r;
  logic [7:0]       th_data_nxt;
  logic             th_push_r;
  logic             th_push_nxt;
  logic             rd_n_r;
  logic             rd_n_nxt;
  logic             wr_n_r;
  logic             wr_n_nxt;
  logic             setup_take;
  logic             sync_take;
  logic             async_take;

  // Mode code to mode; unknown codes leave the port idle.
  function automatic ubpp_mode_t decode_mode(input logic [7:0] code);
    ubpp_mode_t m;
    m = UBPP_MODE_OFF;
    if (code == MODE_ASYNC_CODE) begin
      m = UBPP_MODE_ASYNC;
    end else if (code == MODE_SYNC_CODE) begin
      m = UBPP_MODE_SYNC;
    end
    return m;
  endfunction : decode_mode

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // Setup is taken only between cycles so a direction change never
  // splits a sample/update pair.
  assign setup_ready_o = (state_r == UBPP_S_IDLE);
  assign setup_take    = setup_valid_i && setup_ready_o;
  assign sync_take     = setup_ready_o && !setup_valid_i && (mode_r == UBPP_MODE_SYNC)
                         && fh_valid_i && th_ready_i;
  assign async_take    = setup_ready_o && !setup_valid_i && (mode_r == UBPP_MODE_ASYNC)
                         && fh_valid_i && baud_tick_i;

  // One sample-and-update cycle per host byte in sync mode; async samples on a baud tick in idle with room; strobes are one clock wide.
  always_comb begin
    state_nxt     = state_r;
    mode_nxt      = mode_r;
    hold_nxt      = hold_r;
    th_data_nxt   = th_data_r;
    th_push_nxt   = 1'b0;
    rd_n_nxt      = STROBE_IDLE;
    wr_n_nxt      = STROBE_IDLE;
    fh_ready_o    = 1'b0;
    pif.load_data = 1'b0;
    pif.data      = hold_r;
    pif.load_dir  = 1'b0;
    pif.dir       = setup_mask_i;
    case (state_r)
      UBPP_S_IDLE: begin
        if (setup_take) begin
          mode_nxt     = decode_mode(setup_mode_i);
          pif.load_dir = 1'b1;
        end else if (sync_take) begin
          fh_ready_o  = 1'b1;
          hold_nxt    = fh_data_i;
          th_data_nxt = pin_i;
          th_push_nxt = 1'b1;
          rd_n_nxt    = STROBE_ACTIVE;
          state_nxt   = UBPP_S_FWD;
        end else if ((mode_r == UBPP_MODE_ASYNC) && baud_tick_i) begin
          if (th_ready_i) begin
            th_data_nxt = pin_i;
            th_push_nxt = 1'b1;
            rd_n_nxt    = STROBE_ACTIVE;
          end
          if (async_take) begin
            fh_ready_o    = 1'b1;
            pif.data      = fh_data_i;
            pif.load_data = 1'b1;
            state_nxt     = UBPP_S_SETUP;
          end
        end
      end
      UBPP_S_FWD: begin
        pif.load_data = 1'b1;
        state_nxt     = UBPP_S_SETUP;
      end
      UBPP_S_SETUP: begin
        wr_n_nxt  = STROBE_ACTIVE;
        state_nxt = UBPP_S_WSTB;
      end
      UBPP_S_WSTB: begin
        state_nxt = UBPP_S_IDLE;
      end
      default: begin
        state_nxt = UBPP_S_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r   <= UBPP_S_IDLE;
      mode_r    <= MODE_RST;
      hold_r    <= OUT_RST;
      th_data_r <= OUT_RST;
      th_push_r <= 1'b0;
      rd_n_r    <= STROBE_IDLE;
      wr_n_r    <= STROBE_IDLE;
    end else begin
      state_r   <= state_nxt;
      mode_r    <= mode_nxt;
      hold_r    <= hold_nxt;
      th_data_r <= th_data_nxt;
      th_push_r <= th_push_nxt;
      rd_n_r    <= rd_n_nxt;
      wr_n_r    <= wr_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and pin bank
  // ----------------------------------------------------------------
  // idle-high strobes
  assign pin_sample_strobe_n_o = rd_n_r;
  assign pin_update_strobe_n_o = wr_n_r;
  assign th_valid_o            = th_push_r;
  assign th_data_o             = th_data_r;
  assign mode_o                = mode_r;

  // Pins and their direction latches.
  ubpp_pin_bank u_bank (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .ctl        (pif.bank),
    .pin_o      (pin_o),
    .pin_oe_n_o (pin_oe_n_o)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_sync_order;
    sync_take |=> (!pin_sample_strobe_n_o && th_valid_o && pin_update_strobe_n_o)
      ##1 (pin_sample_strobe_n_o && pin_update_strobe_n_o)
      ##1 !pin_update_strobe_n_o ##1 pin_update_strobe_n_o;
  endproperty
  a_sync_order: assert property (p_sync_order) else $error("sync cycle order broken");

  property p_rd_rise;
    $rose(pin_sample_strobe_n_o) |-> $past(th_valid_o);
  endproperty
  a_rd_rise: assert property (p_rd_rise) else $error("read strobe rose without sample");

  property p_rd_fall;
    th_valid_o |-> !pin_sample_strobe_n_o;
  endproperty
  a_rd_fall: assert property (p_rd_fall) else $error("sample pushed with read high");

  property p_pins_hold;
    !$past(fh_ready_o, 1) && !$past(fh_ready_o, 2) && !$past(setup_take)
      |-> $stable(pin_o);
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pins changed without a byte");

  property p_sync_room;
    (fh_ready_o && mode_r == UBPP_MODE_SYNC) |-> th_ready_i;
  endproperty
  a_sync_room: assert property (p_sync_room) else $error("sync byte taken without room");

  property p_sync_sample_cause;
    (th_valid_o && mode_r == UBPP_MODE_SYNC) |-> $past(fh_ready_o);
  endproperty
  a_sync_sample_cause: assert property (p_sync_sample_cause)
    else $error("sync sample without host byte");

  property p_sample_first;
    sync_take |=> (th_data_o == $past(pin_i)) && $stable(pin_o);
  endproperty
  a_sample_first: assert property (p_sample_first) else $error("sample not before update");

  property p_wr_after_pop;
    fh_ready_o |-> ##[2:3] !pin_update_strobe_n_o;
  endproperty
  a_wr_after_pop: assert property (p_wr_after_pop) else $error("write strobe missing");

  property p_async_tick;
    (fh_ready_o && mode_r == UBPP_MODE_ASYNC) |-> baud_tick_i;
  endproperty
  a_async_tick: assert property (p_async_tick) else $error("async byte without tick");

  property p_dir_hold;
    !setup_take |=> $stable(pin_oe_n_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed without setup");

  property p_inputs_quiet;
    (pin_oe_n_o == ~DIR_ALL_IN) |-> (pin_o == DIR_ALL_IN);
  endproperty
  a_inputs_quiet: assert property (p_inputs_quiet) else $error("input pin driven");

  property p_mode_sel;
    setup_take |=> (mode_r == decode_mode($past(setup_mode_i)));
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode not taken from setup");

  property p_strobe_width;
    $fell(pin_update_strobe_n_o) |=> pin_update_strobe_n_o;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("write strobe too long");

  c_sync_byte: cover property (sync_take ##4 sync_take);
  c_async_byte: cover property (async_take);
  c_all_inputs: cover property (sync_take && pin_oe_n_o == ~DIR_ALL_IN);
  c_sync_stall: cover property (mode_r == UBPP_MODE_SYNC && fh_valid_i && !th_ready_i);

endmodule : ubpp_port

`default_nettype wire

// [sim/ubpp_ext_logic.sv]
/*
  Model of the outside logic on the parallel pins and the two strobes.
  Assumes the strobes and pins are synchronous to the channel clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ubpp_ext_logic (
  input  wire logic        ref_clk_i,    // Channel clock.
  input  wire logic        rst_b_i,      // Async reset, low.
  input  wire logic [7:0]  dev_pin_i,    // Device pin drive.
  input  wire logic [7:0]  dev_oe_n_i,   // Low = device drives.
  input  wire logic [7:0]  ext_val_i,    // Level outside logic drives.
  input  wire logic        samp_stb_n_i, // Read strobe.
  input  wire logic        upd_stb_n_i,  // Write strobe.
  output logic [7:0]       pin_o,        // Resolved pin levels.
  output logic [15:0]      samp_cnt_o,   // Read strobe pulses.
  output logic [15:0]      upd_cnt_o,    // Write strobe pulses.
  output logic [15:0]      gap_o         // Read rise to write fall.
);
  logic        samp_q;
  logic        upd_q;
  logic [15:0] cyc;
  logic [15:0] rise_cyc;

  // per-pin direction
  // Each pin shows the device drive or the outside level.
  always_comb begin
    pin_o = (dev_pin_i & ~dev_oe_n_i) | (ext_val_i & dev_oe_n_i);
  end

  // strobe counting
  // Outside logic samples the strobes on the channel clock; it counts them and the gap.
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      samp_q     <= 1'b1;
      upd_q      <= 1'b1;
      cyc        <= 16'h0000;
      rise_cyc   <= 16'h0000;
      samp_cnt_o <= 16'h0000;
      upd_cnt_o  <= 16'h0000;
      gap_o      <= 16'h0000;
    end else begin
      samp_q <= samp_stb_n_i;
      upd_q  <= upd_stb_n_i;
      cyc    <= cyc + 16'h0001;
      if (samp_q && !samp_stb_n_i) samp_cnt_o <= samp_cnt_o + 16'h0001;
      if (!samp_q && samp_stb_n_i) rise_cyc <= cyc;
      if (upd_q && !upd_stb_n_i) begin
        upd_cnt_o <= upd_cnt_o + 16'h0001;
        gap_o     <= cyc - rise_cyc;
      end
    end
  end
endmodule : ubpp_ext_logic

`default_nettype wire

// [sim/testbench.sv]
/*
  Self-checking bench for the bit-bang parallel port.
  Assumes queue-modelled FIFOs and the outside logic model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
  import ubpp_pkg::*;
  logic        clk, rst_b, setup_valid, setup_ready, baud_tick;
  logic        fh_valid, fh_ready, th_valid, th_room, samp_n, upd_n;
  logic [7:0]  setup_mode, setup_mask, fh_data, th_data;
  logic [7:0]  pin_in, pin_out, pin_oe_n, ext_val;
  logic [15:0] samp_cnt, upd_cnt, gap, sb, ub;
  logic [7:0]  fhq[$];
  logic [7:0]  thq[$];
  ubpp_mode_t  mode;
  int          err_total, checks;

  ubpp_port dut (.ref_clk_i(clk), .rst_b_i(rst_b), .setup_valid_i(setup_valid),
    .setup_mode_i(setup_mode), .setup_mask_i(setup_mask), .setup_ready_o(setup_ready),
    .baud_tick_i(baud_tick), .fh_valid_i(fh_valid), .fh_data_i(fh_data),
    .fh_ready_o(fh_ready), .th_valid_o(th_valid), .th_data_o(th_data),
    .th_ready_i(th_room), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_n_o(pin_oe_n),
    .pin_sample_strobe_n_o(samp_n), .pin_update_strobe_n_o(upd_n), .mode_o(mode));

  ubpp_ext_logic ext (.ref_clk_i(clk), .rst_b_i(rst_b), .dev_pin_i(pin_out),
    .dev_oe_n_i(pin_oe_n), .ext_val_i(ext_val), .samp_stb_n_i(samp_n),
    .upd_stb_n_i(upd_n), .pin_o(pin_in), .samp_cnt_o(samp_cnt),
    .upd_cnt_o(upd_cnt), .gap_o(gap));

  // ----------------------------------------------------------------
  // Clock, FIFO models and watchdog
  // ----------------------------------------------------------------
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pops the host queue on each take and collects pushed samples.
  always @(posedge clk) begin
    if (fh_valid && fh_ready) void'(fhq.pop_front());
    if (th_valid) thq.push_back(th_data);
    fh_valid <= (fhq.size() != 0);
    fh_data  <= (fhq.size() != 0) ? fhq[0] : 8'h00;
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #200000;
    err_total++;
    results();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic setup(input logic [7:0] m, input logic [7:0] k);
    int i;
    setup_valid <= 1'b1;
    setup_mode  <= m;
    setup_mask  <= k;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (setup_ready) break;
    end
    `CHK(i < 50, 1'b1)
    setup_valid <= 1'b0;
    @(posedge clk);
    thq.delete();
    sb = samp_cnt;
    ub = upd_cnt;
  endtask : setup

  task automatic drain(input int n);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (thq.size() >= n && fhq.size() == 0) break;
    end
    `CHK(i < 300, 1'b1)
    repeat (6) @(posedge clk);
  endtask : drain

  task automatic tick();
    baud_tick <= 1'b1;
    @(posedge clk);
    baud_tick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : tick

  task automatic t_sync();
    setup(MODE_SYNC_CODE, 8'hFF);
    `CHK(mode, UBPP_MODE_SYNC)
    `CHK(pin_oe_n, 8'h00)
    fhq = '{8'hFF, 8'h55, 8'hAA, 8'hAA};
    drain(4);
    `CHK(thq.size(), 4)
    `CHK({thq[0], thq[1], thq[2], thq[3]}, {OUT_RST, 8'hFF, 8'h55, 8'hAA})
    `CHK(pin_out, 8'hAA)
    `CHK(upd_cnt - ub, 16'h0004)
    `CHK(samp_cnt - sb, 16'h0004)
    `CHK(gap, 16'h0001)
    repeat (20) @(posedge clk);
    `CHK(thq.size(), 4)
    $display("sync order done");
  endtask : t_sync

  task automatic t_room();
    th_room <= 1'b0;
    thq.delete();
    sb = samp_cnt;
    fhq.push_back(8'h33);
    repeat (12) @(posedge clk);
    `CHK(fhq.size(), 1)
    `CHK(samp_cnt - sb, 16'h0000)
    th_room <= 1'b1;
    drain(1);
    `CHK(thq[0], 8'hAA)
    `CHK(pin_out, 8'h33)
    $display("fifo room done");
  endtask : t_room

  task automatic t_mask();
    setup(MODE_SYNC_CODE, 8'h0F);
    `CHK(pin_oe_n, 8'hF0)
    fhq = '{8'hA5, 8'hA5};
    drain(2);
    `CHK(pin_out, 8'h05)
    `CHK({thq[0], thq[1]}, {8'hC3, 8'hC5})
    `CHK(pin_oe_n, 8'hF0)
    setup(MODE_SYNC_CODE, DIR_ALL_IN);
    `CHK(pin_oe_n, 8'hFF)
    fhq = '{8'h77, 8'h88};
    drain(2);
    `CHK(pin_out, 8'h00)
    `CHK({thq[0], thq[1]}, {8'hC0, 8'hC0})
    `CHK(upd_cnt - ub, 16'h0002)
    $display("direction mask done");
  endtask : t_mask

  task automatic t_async();
    logic [7:0] held;
    setup(8'h02, 8'hFF);
    `CHK(mode, UBPP_MODE_OFF)
    fhq.push_back(8'h11);
    repeat (10) @(posedge clk);
    `CHK(fhq.size(), 1)
    setup(MODE_ASYNC_CODE, 8'hFF);
    `CHK(mode, UBPP_MODE_ASYNC)
    held = pin_out;
    repeat (10) @(posedge clk);
    `CHK(pin_out, held)
    `CHK(fhq.size(), 1)
    tick();
    `CHK(pin_out, 8'h11)
    `CHK(upd_cnt - ub, 16'h0001)
    `CHK(samp_cnt - sb, 16'h0001)
    `CHK(thq[0], 8'h88)
    tick();
    tick();
    `CHK(pin_out, 8'h11)
    `CHK(upd_cnt - ub, 16'h0001)
    fhq = '{8'h22, 8'h3C};
    repeat (2) @(posedge clk);
    tick();
    `CHK(pin_out, 8'h22)
    tick();
    `CHK(pin_out, 8'h3C)
    $display("async pacing done");
  endtask : t_async

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Resets the port, checks idle levels, then runs every scenario.
  initial begin
    err_total   = 0;
    checks      = 0;
    rst_b       = 1'b0;
    setup_valid = 1'b0;
    setup_mode  = 8'h00;
    setup_mask  = 8'h00;
    baud_tick   = 1'b0;
    th_room     = 1'b1;
    ext_val     = 8'hC0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `CHK({samp_n, upd_n}, {STROBE_IDLE, STROBE_IDLE})
    `CHK(pin_oe_n, 8'hFF)
    t_sync();
    t_room();
    t_mask();
    t_async();
    results();
  end
endmodule : testbench

`default_nettype wire
